/* File: osc_mode_pkg.sv */
// package: constants, types and register map of the oscillator mode
// and start-up block; assumes a 50 MHz system clock
package osc_mode_pkg;

  // ****************************************
  // clock rates
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned FAST_OSC_HZ = 8_000_000;
  localparam int unsigned SLOW_OSC_HZ = 31_000;
  localparam logic [15:0] FAST_INC =
    16'((64'(FAST_OSC_HZ) * 64'd65536) / 64'(SYS_CLK_HZ));
  localparam logic [15:0] SLOW_INC =
    16'((64'(SLOW_OSC_HZ) * 64'd65536) / 64'(SYS_CLK_HZ));
  localparam int TRIM_STEP = 40;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int unsigned XTAL_START_COUNT = 1024;
  localparam int unsigned FAST_WARM_CYC = 100;
  localparam int unsigned SLOW_WARM_CYC = 200;
  localparam int unsigned TRIM_SLEW_CYC = 64;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CLOCK_CONTROL_REG_ADDR = 2'h0;
  localparam logic [ADDR_W-1:0] FAST_OSC_TRIM_ADDR = 2'h1;
  localparam int FREQ_SEL_LSB = 4;
  localparam int STARTUP_STAT_BIT = 3;
  localparam int FAST_STABLE_BIT = 2;
  localparam int SLOW_STABLE_BIT = 1;
  localparam int SCS_BIT = 0;
  localparam logic [2:0] FREQ_SEL_RST = 3'h6;
  localparam logic SCS_RST = 1'b0;
  localparam logic [4:0] TRIM_RST = 5'h00;
  localparam logic [2:0] FREQ_SEL_SLOW = 3'h0;
  localparam logic [2:0] FREQ_SEL_MAX = 3'h7;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    low_gain_crystal_mode,
    medium_gain_crystal_mode,
    high_gain_crystal_mode,
    external_logic_clock_mode,
    resistor_capacitor_mode,
    resistor_capacitor_pin_mode,
    internal_clock_out_mode,
    internal_clock_pin_mode
  } osc_mode_e;

  typedef enum logic [1:0] {gain_off, gain_low, gain_medium, gain_high} amp_gain_e;

  typedef enum {st_power_up_delay_timer_wait, st_xtal_count, st_run} startup_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic clock_in_function_gpio;
    logic quarter_clock_output_gpio;
    logic quarter_clock_output_oe;
    logic quarter_clock_output;
  } pin_ctl_s;

endpackage

/* File: osc_mode_startup.sv */
// oscillator mode decode, crystal start-up count, internal oscillator
// models with trim and postscaler, quarter clock output, registers
// assumes: config bits static, power_up_delay_timer_expired and wake_req are
// one-cycle pulses on sys_clk, clock_input_pin is asynchronous
// Summary of operation
// - crystal modes wait 1024 input-pin oscillations before releasing the clock
// - start-up count runs after power-on, after delay timer expiry, and on wake
// - core is held while the start-up count runs
// - external logic-clock mode skips the start-up count entirely
// - external logic clock feeds system clock; output pin becomes I/O
// - logic is static: stopped input clock freezes state, restart resumes
// - crystal modes decode to low, medium or high amplifier gain
// - RC mode drives the output pin with oscillator divided by four
// - RC pin mode keeps RC on input pin; output pin is I/O
// - internal clock-out mode frees input pin, outputs internal clock over four
// - internal pin mode frees both clock pins as I/O
// - both internal modes make internal oscillators the clock source
// - two internal oscillators: fast 8 MHz calibrated, slow 31 kHz
// - source select bit picks external or internal clock
// - fast oscillator postscaler offers seven selectable frequencies
// - fast oscillator runs if select nonzero and source bit, two-speed or an internal mode set
// - a status bit reports fast oscillator stable
// - trim is 5-bit two's complement, resets to zero
// - after trim write frequency drifts; no completion indication
// - trim never affects the slow oscillator
// - select 7..1 is 8 MHz halving to 125 kHz, 0 slow; default 6
// - any reset clears the source select bit
`timescale 1ns/1ps
module osc_mode_startup
  import osc_mode_pkg::*;
#(
  parameter int unsigned XTAL_COUNT = XTAL_START_COUNT,
  parameter int unsigned FAST_WARM = FAST_WARM_CYC,
  parameter int unsigned SLOW_WARM = SLOW_WARM_CYC,
  parameter int unsigned TRIM_SLEW = TRIM_SLEW_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] osc_mode_cfg,
  input wire logic two_speed_startup_enable,
  input wire logic power_up_delay_timer_enable,
  input wire logic watchdog_enable,
  input wire logic fail_safe_enable,
  input wire logic power_up_delay_timer_expired,
  input wire logic wake_req,
  input wire logic clock_input_pin,
  input wire reg_req_s reg_req,
  output logic [DATA_W-1:0] rd_data_q,
  output logic sys_clk_en_q,
  output logic core_hold_q,
  output amp_gain_e amp_gain_q,
  output pin_ctl_s pin_ctl_q,
  output logic fast_osc_run_q,
  output logic slow_osc_run_q
);

  if (XTAL_COUNT < 2 || XTAL_COUNT > 65535 || FAST_WARM < 1 || SLOW_WARM < 1
      || TRIM_SLEW < 1 || TRIM_SLEW > 65535) begin : g_chk
    $error("osc_mode_startup: unsupported parameter value");
  end

  osc_mode_e mode;
  assign mode = osc_mode_e'(osc_mode_cfg);

  function automatic logic is_xtal(input osc_mode_e m);
    return m == low_gain_crystal_mode || m == medium_gain_crystal_mode
        || m == high_gain_crystal_mode;
  endfunction

  function automatic logic is_internal(input osc_mode_e m);
    return m == internal_clock_out_mode || m == internal_clock_pin_mode;
  endfunction

  function automatic logic [6:0] post_mask(input logic [2:0] sel);
    return 7'((8'h01 << (3'h7 - sel)) - 8'h01);
  endfunction

  function automatic logic [15:0] fast_inc(input logic signed [4:0] t);
    return 16'(int'(FAST_INC) + int'(t) * TRIM_STEP);
  endfunction

  // ****************************************
  // input pin synchroniser
  // ****************************************
  logic [2:0] pin_sync_q;
  logic pin_level_q, pin_level_d, pin_rise;

  always_comb begin
    pin_level_d = pin_level_q;
    if (pin_sync_q[1] == pin_sync_q[2]) begin
      pin_level_d = pin_sync_q[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], clock_input_pin};
      pin_level_q <= pin_level_d;
    end
  end

  assign pin_rise = pin_level_d && !pin_level_q;

  // ****************************************
  // registers
  // ****************************************
  logic [2:0] freq_sel_q, freq_sel_d;
  logic scs_q, scs_d;
  logic [4:0] trim_q, trim_d;
  logic [DATA_W-1:0] rd_data_d;
  logic fast_stable, slow_stable, ext_running;
  startup_e st_q, st_d;

  always_comb begin
    freq_sel_d = freq_sel_q;
    scs_d = scs_q;
    trim_d = trim_q;
    rd_data_d = '0;
    if (reg_req.wr && reg_req.addr == CLOCK_CONTROL_REG_ADDR) begin
      freq_sel_d = reg_req.wdata[FREQ_SEL_LSB +: 3];
      scs_d = reg_req.wdata[SCS_BIT];
    end
    if (reg_req.wr && reg_req.addr == FAST_OSC_TRIM_ADDR) begin
      trim_d = reg_req.wdata[4:0];
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        CLOCK_CONTROL_REG_ADDR: begin
          rd_data_d[FREQ_SEL_LSB +: 3] = freq_sel_q;
          rd_data_d[STARTUP_STAT_BIT] = ext_running;
          rd_data_d[FAST_STABLE_BIT] = fast_stable;
          rd_data_d[SLOW_STABLE_BIT] = slow_stable;
          rd_data_d[SCS_BIT] = scs_q;
        end
        FAST_OSC_TRIM_ADDR: rd_data_d[4:0] = trim_q;
        default: rd_data_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      freq_sel_q <= FREQ_SEL_RST;
      scs_q <= SCS_RST;
      trim_q <= TRIM_RST;
      rd_data_q <= '0;
    end else begin
      freq_sel_q <= freq_sel_d;
      scs_q <= scs_d;
      trim_q <= trim_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // crystal start-up sequence
  // ****************************************
  logic [15:0] xtal_cnt_q, xtal_cnt_d;
  logic start_evt;

  always_comb begin
    st_d = st_q;
    xtal_cnt_d = xtal_cnt_q;
    start_evt = 1'b0;
    case (st_q)
      st_power_up_delay_timer_wait: start_evt = !power_up_delay_timer_enable || power_up_delay_timer_expired;
      st_xtal_count: begin
        if (pin_rise) begin
          xtal_cnt_d = xtal_cnt_q + 16'h0001;
          if (xtal_cnt_q == 16'(XTAL_COUNT - 1)) begin
            st_d = st_run;
          end
        end
      end
      st_run: start_evt = wake_req;
      default: st_d = st_power_up_delay_timer_wait;
    endcase
    if (start_evt) begin
      st_d = is_xtal(mode) ? st_xtal_count : st_run;
      xtal_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= st_power_up_delay_timer_wait;
      xtal_cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      xtal_cnt_q <= xtal_cnt_d;
    end
  end

  // ****************************************
  // internal oscillators
  // ****************************************
  logic [4:0] trim_eff_q, trim_eff_d;
  logic [15:0] slew_cnt_q, slew_cnt_d;
  logic [15:0] fast_acc_q, fast_acc_d, slow_acc_q, slow_acc_d;
  logic [6:0] post_q, post_d;
  logic [15:0] fast_warm_q, fast_warm_d, slow_warm_q, slow_warm_d;
  logic fast_run, slow_run, fast_tick, slow_tick, int_tick;
  logic [16:0] fast_sum, slow_sum;

  assign fast_run = freq_sel_q != FREQ_SEL_SLOW && (scs_q || two_speed_startup_enable
                    || is_internal(mode));
  assign slow_run = (freq_sel_q == FREQ_SEL_SLOW && (scs_q || two_speed_startup_enable
                    || is_internal(mode))) || power_up_delay_timer_enable || watchdog_enable
                    || fail_safe_enable;
  assign fast_stable = fast_warm_q == 16'(FAST_WARM);
  assign slow_stable = slow_warm_q == 16'(SLOW_WARM);

  always_comb begin
    trim_eff_d = trim_eff_q;
    slew_cnt_d = slew_cnt_q + 16'h0001;
    // trim drifts one step per slew period
    if (slew_cnt_q == 16'(TRIM_SLEW - 1)) begin
      slew_cnt_d = 16'h0000;
      if ($signed(trim_eff_q) < $signed(trim_q)) begin
        trim_eff_d = trim_eff_q + 5'h01;
      end else if ($signed(trim_eff_q) > $signed(trim_q)) begin
        trim_eff_d = trim_eff_q - 5'h01;
      end
    end
    fast_sum = {1'b0, fast_acc_q} + {1'b0, fast_inc($signed(trim_eff_q))};
    slow_sum = {1'b0, slow_acc_q} + {1'b0, SLOW_INC};
    fast_acc_d = fast_run ? fast_sum[15:0] : fast_acc_q;
    slow_acc_d = slow_run ? slow_sum[15:0] : slow_acc_q;
    fast_tick = fast_run && fast_stable && fast_sum[16];
    slow_tick = slow_run && slow_stable && slow_sum[16];
    post_d = fast_tick ? post_q + 7'h01 : post_q;
    fast_warm_d = !fast_run ? 16'h0000 : (fast_stable ? fast_warm_q : fast_warm_q + 16'h0001);
    slow_warm_d = !slow_run ? 16'h0000 : (slow_stable ? slow_warm_q : slow_warm_q + 16'h0001);
    if (freq_sel_q == FREQ_SEL_SLOW) begin
      int_tick = slow_tick;
    end else begin
      int_tick = fast_tick && ((post_q & post_mask(freq_sel_q)) == post_mask(freq_sel_q));
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trim_eff_q <= TRIM_RST;
      slew_cnt_q <= 16'h0000;
      fast_acc_q <= 16'h0000;
      slow_acc_q <= 16'h0000;
      post_q <= 7'h00;
      fast_warm_q <= 16'h0000;
      slow_warm_q <= 16'h0000;
    end else begin
      trim_eff_q <= trim_eff_d;
      slew_cnt_q <= slew_cnt_d;
      fast_acc_q <= fast_acc_d;
      slow_acc_q <= slow_acc_d;
      post_q <= post_d;
      fast_warm_q <= fast_warm_d;
      slow_warm_q <= slow_warm_d;
    end
  end

  // ****************************************
  // clock selection and pin control
  // ****************************************
  logic use_int, src_tick, div_q, div_d;
  logic sys_clk_en_d, core_hold_d;
  amp_gain_e amp_gain_d;
  pin_ctl_s pin_ctl_d;

  assign use_int = scs_q || is_internal(mode);
  assign ext_running = !use_int && st_q == st_run;

  always_comb begin
    // selected source edges only: internal tick or input-pin rise; no edge, no progress
    src_tick = use_int ? int_tick : pin_rise;
    core_hold_d = st_d != st_run;
    sys_clk_en_d = src_tick && !core_hold_d;
    div_d = div_q;
    pin_ctl_d = pin_ctl_q;
    pin_ctl_d.clock_in_function_gpio = 1'b0;
    pin_ctl_d.quarter_clock_output_gpio = 1'b0;
    pin_ctl_d.quarter_clock_output_oe = 1'b0;
    amp_gain_d = gain_off;
    case (mode)
      low_gain_crystal_mode: amp_gain_d = gain_low;
      medium_gain_crystal_mode: amp_gain_d = gain_medium;
      high_gain_crystal_mode: amp_gain_d = gain_high;
      external_logic_clock_mode: pin_ctl_d.quarter_clock_output_gpio = 1'b1;
      resistor_capacitor_mode: pin_ctl_d.quarter_clock_output_oe = 1'b1;
      resistor_capacitor_pin_mode: pin_ctl_d.quarter_clock_output_gpio = 1'b1;
      internal_clock_out_mode: begin
        pin_ctl_d.clock_in_function_gpio = 1'b1;
        pin_ctl_d.quarter_clock_output_oe = 1'b1;
      end
      internal_clock_pin_mode: begin
        pin_ctl_d.clock_in_function_gpio = 1'b1;
        pin_ctl_d.quarter_clock_output_gpio = 1'b1;
      end
      default: amp_gain_d = gain_off;
    endcase
    // two source edges per half period gives fosc/4
    if (pin_ctl_d.quarter_clock_output_oe && src_tick) begin
      div_d = !div_q;
      if (div_q) begin
        pin_ctl_d.quarter_clock_output = !pin_ctl_q.quarter_clock_output;
      end
    end
    if (!pin_ctl_d.quarter_clock_output_oe) begin
      pin_ctl_d.quarter_clock_output = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 1'b0;
      sys_clk_en_q <= 1'b0;
      core_hold_q <= 1'b1;
      amp_gain_q <= gain_off;
      pin_ctl_q <= '0;
      fast_osc_run_q <= 1'b0;
      slow_osc_run_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sys_clk_en_q <= sys_clk_en_d;
      core_hold_q <= core_hold_d;
      amp_gain_q <= amp_gain_d;
      pin_ctl_q <= pin_ctl_d;
      fast_osc_run_q <= fast_run;
      slow_osc_run_q <= slow_run;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_last_edge;
    st_q == st_xtal_count && pin_rise && xtal_cnt_q == 16'(XTAL_COUNT - 1);
  endsequence
  sequence s_released;
    st_q == st_run ##1 !core_hold_q;
  endsequence

  property p_xtal_release;
    s_last_edge |=> s_released;
  endproperty
  a_xtal_release: assert property (p_xtal_release) else $error("start-up not released");

  property p_xtal_wait;
    st_q == st_xtal_count && !pin_rise |=> st_q == st_xtal_count;
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("start-up ended early");

  property p_hold;
    st_q != st_run |-> core_hold_q && !sys_clk_en_q;
  endproperty
  a_hold: assert property (p_hold) else $error("core ran during start-up");

  property p_ext_nodelay;
    st_q == st_run && wake_req && !is_xtal(mode) |=> st_q == st_run;
  endproperty
  a_ext_nodelay: assert property (p_ext_nodelay) else $error("count in non-crystal mode");

  property p_wake_restart;
    st_q == st_run && wake_req && is_xtal(mode) |=> st_q == st_xtal_count && xtal_cnt_q == 0;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("wake did not restart");

  property p_gain;
    mode == medium_gain_crystal_mode ##1 mode == medium_gain_crystal_mode
      |-> amp_gain_q == gain_medium;
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");

  property p_quarter;
    mode == resistor_capacitor_mode && pin_ctl_q.quarter_clock_output_oe && pin_rise && div_q
      |=> pin_ctl_q.quarter_clock_output != $past(pin_ctl_q.quarter_clock_output);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter clock missed toggle");

  property p_intout_pins;
    mode == internal_clock_out_mode ##1 mode == internal_clock_out_mode
      |-> pin_ctl_q.clock_in_function_gpio && pin_ctl_q.quarter_clock_output_oe && !pin_ctl_q.quarter_clock_output_gpio;
  endproperty
  a_intout_pins: assert property (p_intout_pins) else $error("clock-out pins wrong");

  property p_fast_run;
    freq_sel_q != FREQ_SEL_SLOW && scs_q |=> fast_osc_run_q;
  endproperty
  a_fast_run: assert property (p_fast_run) else $error("fast osc not running");

  property p_slow_untrimmed;
    slow_run |=> slow_acc_q == 16'($past(slow_acc_q) + SLOW_INC);
  endproperty
  a_slow_untrimmed: assert property (p_slow_untrimmed) else $error("slow osc rate moved");

  property p_trim_drift;
    reg_req.wr && reg_req.addr == FAST_OSC_TRIM_ADDR |=> trim_eff_q == $past(trim_eff_q);
  endproperty
  a_trim_drift: assert property (p_trim_drift) else $error("trim jumped");

  property p_read_select;
    reg_req.rd && reg_req.addr == CLOCK_CONTROL_REG_ADDR
      |=> rd_data_q[FREQ_SEL_LSB +: 3] == $past(freq_sel_q) && rd_data_q[7] == 1'b0;
  endproperty
  a_read_select: assert property (p_read_select) else $error("select readback wrong");

endmodule

/* File: ext_clock_source.sv */
// behavioural clock source on the clock input pin: crystal, RC network
// or logic clock; assumes a free running sys_clk and half_cyc >= 2
`timescale 1ns/1ps
module ext_clock_source (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [7:0] half_cyc,
  output logic clock_input_pin
);
  logic [7:0] cnt_q = 8'h00;

  initial clock_input_pin = 1'b0;

  // ****************************************
  // source oscillation
  // ****************************************
  // stands low while stopped, so no stray edge reaches the pin
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt_q <= 8'h00;
      clock_input_pin <= 1'b0;
    end else if (cnt_q == half_cyc - 8'h01) begin
      cnt_q <= 8'h00;
      clock_input_pin <= ~clock_input_pin;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: tb_top.sv */
// testbench of the oscillator mode and start-up block
// assumes the design package and ext_clock_source are compiled first
`timescale 1ns/1ps
module tb_top import osc_mode_pkg::*; ;
  localparam int unsigned XC = 8;
  localparam int unsigned WRM = 4;
  localparam int unsigned LIMIT = 20000;
  // pin roles {clock_in_function_gpio, quarter_clock_output_gpio, quarter_clock_output_oe} per mode, mode 7 first
  localparam logic [23:0] PINS = {3'h6, 3'h5, 3'h2, 3'h1, 3'h2, 3'h0, 3'h0, 3'h0};

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] mode_cfg = 3'h0;
  logic two_spd = 1'b0;
  logic power_up_delay_timer_en = 1'b0;
  logic power_up_delay_timer_exp = 1'b0;
  logic wake = 1'b0;
  logic run = 1'b0;
  logic slow_user = 1'b0;
  reg_req_s req = '0;
  wire pin;
  logic [DATA_W-1:0] rd_data_q;
  logic sys_clk_en_q, core_hold_q, fast_osc_run_q, slow_osc_run_q, last_ck;
  amp_gain_e amp_gain_q;
  pin_ctl_s pin_ctl_q;
  int unsigned failures = 0;
  int unsigned checks_done = 0;
  int unsigned toggles = 0;
  int unsigned pulses = 0;
  int unsigned cycles = 0;

  always #10 sys_clk = ~sys_clk;

  osc_mode_startup #(.XTAL_COUNT(XC), .FAST_WARM(WRM), .SLOW_WARM(WRM),
    .TRIM_SLEW(WRM)) osc_mode_startup_i (
    .sys_clk(sys_clk), .rstn(rstn), .osc_mode_cfg(mode_cfg),
    .two_speed_startup_enable(two_spd), .power_up_delay_timer_enable(power_up_delay_timer_en),
    .watchdog_enable(slow_user), .fail_safe_enable(slow_user), .power_up_delay_timer_expired(power_up_delay_timer_exp),
    .wake_req(wake), .clock_input_pin(pin), .reg_req(req), .rd_data_q(rd_data_q),
    .sys_clk_en_q(sys_clk_en_q), .core_hold_q(core_hold_q), .amp_gain_q(amp_gain_q),
    .pin_ctl_q(pin_ctl_q), .fast_osc_run_q(fast_osc_run_q),
    .slow_osc_run_q(slow_osc_run_q));

  ext_clock_source ext_clock_source_i (.sys_clk(sys_clk), .run(run),
    .half_cyc(8'h06), .clock_input_pin(pin));

  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge sys_clk) begin
    last_ck <= pin_ctl_q.quarter_clock_output;
    if (pin_ctl_q.quarter_clock_output !== last_ck) toggles <= toggles + 1;
    if (sys_clk_en_q === 1'b1) pulses <= pulses + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int unsigned n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_rises(input int unsigned n);
    repeat (n) @(posedge pin);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    d = rd_data_q;
  endtask

  task automatic pulse_in(input bit is_wake);
    @(posedge sys_clk);
    if (is_wake) wake <= 1'b1;
    else power_up_delay_timer_exp <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    power_up_delay_timer_exp <= 1'b0;
  endtask

  task automatic do_reset(input logic [2:0] m, input logic pe, input logic ts);
    @(posedge sys_clk);
    rstn <= 1'b0;
    run <= 1'b0;
    mode_cfg <= m;
    power_up_delay_timer_en <= pe;
    two_spd <= ts;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(1);
  endtask

  // counts toggles and pulses over n pin rises, or over c cycles if n is 0
  task automatic meas(input int unsigned n, input int unsigned c, output int unsigned dt,
    output int unsigned dp);
    int unsigned t0, p0;
    if (n > 0) begin
      wait_rises(1);
      tick(9);
    end
    t0 = toggles;
    p0 = pulses;
    if (n > 0) begin
      wait_rises(n);
      tick(9);
    end else tick(c);
    dt = toggles - t0;
    dp = pulses - p0;
  endtask

  task automatic xtal_count();
    run <= 1'b1;
    wait_rises(XC - 1);
    tick(9);
    check("hold_before_last", core_hold_q, 1'b1);
    wait_rises(1);
    tick(9);
    check("hold_after_last", core_hold_q, 1'b0);
    run <= 1'b0;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] d;
    int unsigned dt, dp, e;
    for (int m = 0; m < 8; m++) begin
      do_reset(3'(m), 1'b0, 1'b0);
      tick(20);
      check("gain", amp_gain_q, (m < 3) ? 32'(m + 1) : 32'h0);
      check("pins", pin_ctl_q[3:1], PINS[m*3 +: 3]);
      check("hold", core_hold_q, m < 3);
      check("fast_run", fast_osc_run_q, m >= 6);
      rd(CLOCK_CONTROL_REG_ADDR, d);
      check("sel_reset", d[6:4], 3'h6);
      check("src_reset", {d[7], d[0]}, 2'h0);
      check("run_ext", d[3], m >= 3 && m <= 5);
      check("fast_stable", d[2], m >= 6);
      rd(FAST_OSC_TRIM_ADDR, d);
      check("trim_reset", d, 8'h00);
      rd(2'h2, d);
      check("unmapped", d, 8'h00);
      if (m < 3) begin
        xtal_count();
        tick(20);
        pulse_in(1'b1);
        tick(9);
        check("hold_wake", core_hold_q, 1'b1);
        xtal_count();
      end
    end
    // external logic clock behind the delay timer, two-speed on
    do_reset(3'h3, 1'b1, 1'b1);
    tick(20);
    check("hold_power_up_delay_timer", core_hold_q, 1'b1);
    check("fast_two_speed", fast_osc_run_q, 1'b1);
    pulse_in(1'b0);
    tick(4);
    check("hold_ext", core_hold_q, 1'b0);
    pulse_in(1'b1);
    tick(2);
    check("hold_ext_wake", core_hold_q, 1'b0);
    run <= 1'b1;
    meas(16, 0, dt, dp);
    check("ext_ticks", dp, 16);
    run <= 1'b0;
    tick(20);
    meas(0, 50, dt, dp);
    check("stopped_ticks", dp, 0);
    run <= 1'b1;
    meas(16, 0, dt, dp);
    check("resumed_ticks", dp, 16);
    run <= 1'b0;
    wr(CLOCK_CONTROL_REG_ADDR, 8'h71);
    tick(20);
    check("fast_scs", fast_osc_run_q, 1'b1);
    meas(0, 100, dt, dp);
    check("int_ticks", dp >= 15 && dp <= 17, 1'b1);
    rd(CLOCK_CONTROL_REG_ADDR, d);
    check("ctl_rw", {d[6:4], d[2], d[0]}, 5'h1f);
    check("ext_status", d[3], 1'b0);
    wr(CLOCK_CONTROL_REG_ADDR, 8'h01);
    tick(20);
    check("fast_off", fast_osc_run_q, 1'b0);
    check("slow_on", slow_osc_run_q, 1'b1);
    rd(CLOCK_CONTROL_REG_ADDR, d);
    check("slow_stable", d[1], 1'b1);
    wr(FAST_OSC_TRIM_ADDR, 8'hff);
    rd(FAST_OSC_TRIM_ADDR, d);
    check("trim_rw", d, 8'h1f);
    // resistor-capacitor mode quarter clock
    do_reset(3'h4, 1'b0, 1'b0);
    run <= 1'b1;
    meas(16, 0, dt, dp);
    check("rc_quarter", dt, 8);
    run <= 1'b0;
    // internal clock-out mode over three selections, then trimmed
    do_reset(3'h6, 1'b0, 1'b0);
    rd(CLOCK_CONTROL_REG_ADDR, d);
    check("src_cleared", d[0], 1'b0);
    for (int s = 5; s < 8; s++) begin
      wr(CLOCK_CONTROL_REG_ADDR, {1'b0, 3'(s), 4'h0});
      tick(50);
      meas(0, 1000, dt, dp);
      e = 80 >> (7 - s);
      check("int_quarter", dt + 1 >= e && dt <= e + 1, 1'b1);
    end
    wr(FAST_OSC_TRIM_ADDR, 8'h0f);
    tick(100);
    meas(0, 1000, dt, dp);
    check("trim_faster", dt >= 83, 1'b1);
    check("slow_idle", slow_osc_run_q, 1'b0);
    @(posedge sys_clk);
    slow_user <= 1'b1;
    tick(2);
    check("slow_watchdog", slow_osc_run_q, 1'b1);
    close_out();
  end
endmodule
